/* File: pkg/cfl_pkg.sv */
/*
 * shared constants, states and pin bundles of the serial configuration
 * loader. assumes a 100 MHz system clock; all pin timing derives from it.
 */
`default_nettype none
package cfl_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CNT_W = 24;
    localparam int T_STATUS_MIN_US = 268;
    localparam int STATUS_CYC_DEF =
        (T_STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CCLK_MAX_MHZ = 125;
    localparam int CU_PERIODS = 4;
    localparam int CU_NS = CU_PERIODS * 1000 / CCLK_MAX_MHZ;
    localparam int CU_CYC = (CU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CYCLES = 8576;
    localparam int OSC_DIV = 4;
    localparam int POR_CYC_DEF = 1000;
    localparam int IMAGE_BITS_DEF = 256;
    localparam int WAIT_FALLS = 2;
    // ==========================================================
    // data path
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [CNT_W-1:0] CU_CNT = CNT_W'(CU_CYC);
    localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_DIV - 1);
    localparam logic [CNT_W-1:0] FALL_LAST = CNT_W'(WAIT_FALLS - 1);
    localparam logic [13:0] INIT_LAST = 14'(INIT_CYCLES - 1);
    // ==========================================================
    // states, gray along the usual path
    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_HOLD = 3'h1,
        ST_STAT = 3'h3,
        ST_LOAD = 3'h2,
        ST_WAIT2 = 3'h6,
        ST_INIT = 3'h7,
        ST_USER = 3'h5,
        ST_ERR = 3'h4
    } cfl_state_t;
    typedef enum logic [1:0] {
        SRC_OSC = 2'h0,
        SRC_USER = 2'h1,
        SRC_CCLK = 2'h2
    } cfl_src_t;
    typedef struct packed {
        logic config_req_n;
        logic config_clock;
        logic serial_config_in;
        logic user_init_clock;
        logic status_i;
    } cfl_pins_in_t;
    typedef struct packed {
        logic status_o;
        logic status_oe;
        logic done_o;
        logic done_oe;
        logic initd_o;
        logic initd_oe;
    } cfl_pins_out_t;
endpackage
`default_nettype wire

/* File: rtl/cfl_fifo.sv */
/*
 * byte buffer between the serial shifter and the image consumer.
 * assumes depth is a power of two; one clock, clock enable, sync clear.
 */
`timescale 1ns/1ps
`default_nettype none
module cfl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic push, pop;

    // ==========================================================
    // pointers; extra top bit tells full from empty
    always_comb begin
        in_ready = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
        out_valid = wr_r != rd_r;
        out_data = mem_r[rd_r[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_nxt = clr ? '0 : wr_r + (AW+1)'(push);
        rd_nxt = clr ? '0 : rd_r + (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
        end else if (ce) begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_r[wr_r[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/cfl_loader.sv */
/*
 * passive serial configuration port with start-up initialization.
 * assumes all pins come from outside the mclk domain; open-drain lines
 * are resolved outside from the _oe outputs with pull-ups.
 */
`timescale 1ns/1ps
`default_nettype none
module cfl_loader #(
    parameter int POR_CYC = cfl_pkg::POR_CYC_DEF,
    parameter int STATUS_LOW_CYC = cfl_pkg::STATUS_CYC_DEF,
    parameter int IMAGE_BITS = cfl_pkg::IMAGE_BITS_DEF
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire cfl_pkg::cfl_pins_in_t pins_in,
    output cfl_pkg::cfl_pins_out_t pins_out,
    input wire logic [1:0] init_clk_sel,
    input wire logic init_done_en,
    output logic user_mode,
    output logic user_io_in,
    output logic [cfl_pkg::BYTE_W-1:0] image_data,
    output logic image_valid,
    input wire logic image_ready
);
    import cfl_pkg::*;

    localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYC - 1);
    localparam logic [CNT_W-1:0] STAT_END = CNT_W'(STATUS_LOW_CYC - 1);
    localparam logic [CNT_W-1:0] IMG_END = CNT_W'(IMAGE_BITS);

    // ==========================================================
    // pin synchronisers
    cfl_pins_in_t pin_q_r, pin_s_r, pin_p_r;
    logic cclk_rise, cclk_fall, uclk_rise;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_q_r <= '0;
            pin_s_r <= '0;
            pin_p_r <= '0;
        end else if (clk_en) begin
            pin_q_r <= pins_in;
            pin_s_r <= pin_q_r;
            pin_p_r <= pin_s_r;
        end
    end

    assign cclk_rise = pin_s_r.config_clock && !pin_p_r.config_clock;
    assign cclk_fall = !pin_s_r.config_clock && pin_p_r.config_clock;
    assign uclk_rise = pin_s_r.user_init_clock && !pin_p_r.user_init_clock;

    // ==========================================================
    // buffer in the image path
    logic push_r, push_nxt;
    logic [BYTE_W-1:0] shift_r, shift_nxt, byte_r, byte_nxt;
    logic fifo_ready, fifo_clr;
    logic fifo_valid;
    logic [BYTE_W-1:0] fifo_data;

    cfl_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst_n(resetn),
        .ce(clk_en),
        .clr(fifo_clr),
        .in_valid(push_r),
        .in_ready(fifo_ready),
        .in_data(byte_r),
        .out_valid(fifo_valid),
        .out_ready(img_load),
        .out_data(fifo_data)
    );

    // ==========================================================
    // sequencer
    cfl_state_t st_r, st_nxt;
    cfl_src_t src_r, src_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt, bit_cnt_r, bit_cnt_nxt;
    logic [2:0] nbit_r, nbit_nxt;
    logic [13:0] init_cnt_r, init_cnt_nxt;
    logic initd_en_r, initd_en_nxt;
    logic tick;
    cfl_pins_out_t od_r, od_nxt;
    logic user_mode_r, user_io_r, img_valid_r;
    logic [BYTE_W-1:0] img_data_r;
    logic img_load, img_valid_nxt;
    logic [BYTE_W-1:0] img_data_nxt;

    always_comb begin
        st_nxt = st_r;
        src_nxt = src_r;
        cnt_nxt = cnt_r;
        bit_cnt_nxt = bit_cnt_r;
        nbit_nxt = nbit_r;
        shift_nxt = shift_r;
        byte_nxt = byte_r;
        push_nxt = 1'b0;
        init_cnt_nxt = init_cnt_r;
        initd_en_nxt = initd_en_r;
        fifo_clr = 1'b0;
        tick = 1'b0;
        unique case (st_r)
            ST_POR: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == POR_LAST) begin
                    cnt_nxt = '0;
                    st_nxt = pin_s_r.config_req_n ? ST_LOAD : ST_HOLD;
                end
            end
            ST_HOLD: begin
                cnt_nxt = '0;
                fifo_clr = 1'b1;
                if (pin_s_r.config_req_n) begin
                    st_nxt = ST_STAT;
                end
            end
            // minimum low time, then wait for the line
            ST_STAT: begin
                if (cnt_r != STAT_END) begin
                    cnt_nxt = cnt_r + 1'b1;
                end else if (pin_s_r.status_i) begin
                    st_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                cnt_nxt = '0;
                // one bit per rising edge, first bit lowest
                if (cclk_rise && bit_cnt_r != IMG_END) begin
                    shift_nxt = {pin_s_r.serial_config_in, shift_r[7:1]};
                    bit_cnt_nxt = bit_cnt_r + 1'b1;
                    nbit_nxt = nbit_r + 1'b1;
                    if (nbit_r == BIT_LAST) begin
                        byte_nxt = shift_nxt;
                        push_nxt = 1'b1;
                    end
                end
                // a byte the buffer cannot take spoils the image
                if (push_r && !fifo_ready) begin
                    st_nxt = ST_ERR;
                end else if (bit_cnt_r == IMG_END && !push_r) begin
                    st_nxt = ST_WAIT2;
                    initd_en_nxt = init_done_en;
                end
            end
            ST_WAIT2: begin
                if (cclk_fall) begin
                    cnt_nxt = cnt_r + 1'b1;
                    if (cnt_r == FALL_LAST) begin
                        cnt_nxt = '0;
                        st_nxt = ST_INIT;
                        src_nxt = cfl_src_t'(init_clk_sel);
                    end
                end
            end
            ST_INIT: begin
                case (src_r)
                    SRC_USER: begin
                        // user clock only after the settle delay
                        if (cnt_r != CU_CNT) begin
                            cnt_nxt = cnt_r + 1'b1;
                        end else begin
                            tick = uclk_rise;
                        end
                    end
                    SRC_CCLK: tick = cclk_rise;
                    default: begin
                        cnt_nxt = (cnt_r == OSC_LAST) ? '0 : cnt_r + 1'b1;
                        tick = cnt_r == OSC_LAST;
                    end
                endcase
                if (tick) begin
                    init_cnt_nxt = init_cnt_r + 1'b1;
                    if (init_cnt_r == INIT_LAST) begin
                        st_nxt = ST_USER;
                    end
                end
            end
            ST_USER: cnt_nxt = '0;
            ST_ERR: cnt_nxt = '0;
        endcase
        // request low restarts from any state except ST_POR
        if (!pin_s_r.config_req_n && st_r != ST_POR) begin
            st_nxt = ST_HOLD;
        end
        if (st_nxt == ST_HOLD) begin
            bit_cnt_nxt = '0;
            nbit_nxt = '0;
            init_cnt_nxt = '0;
            push_nxt = 1'b0;
        end
    end

    // ==========================================================
    // output stage; refills when empty or taken, so a byte
    // moves only on an edge with image_valid and image_ready
    always_comb begin
        img_load = !img_valid_r || image_ready;
        img_valid_nxt = img_valid_r;
        img_data_nxt = img_data_r;
        if (fifo_clr) begin
            img_valid_nxt = 1'b0;
        end else if (img_load) begin
            img_valid_nxt = fifo_valid;
            img_data_nxt = fifo_data;
        end
    end

    // ==========================================================
    // pin drive, from next state so lines move with the state
    always_comb begin
        od_nxt = '0;
        // request low pulls both lines low
        od_nxt.status_oe = st_nxt == ST_POR || st_nxt == ST_HOLD
            || st_nxt == ST_ERR
            || (st_nxt == ST_STAT && cnt_nxt != STAT_END);
        // done low until the image is in
        od_nxt.done_oe = !(st_nxt == ST_WAIT2 || st_nxt == ST_INIT
            || st_nxt == ST_USER);
        // init-complete pin low while starting up
        od_nxt.initd_oe = initd_en_nxt
            && (st_nxt == ST_WAIT2 || st_nxt == ST_INIT);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r <= ST_POR;
            src_r <= SRC_OSC;
            cnt_r <= '0;
            bit_cnt_r <= '0;
            nbit_r <= '0;
            shift_r <= '0;
            byte_r <= '0;
            push_r <= 1'b0;
            init_cnt_r <= '0;
            initd_en_r <= 1'b0;
            od_r <= 6'b01_0100;
            user_mode_r <= 1'b0;
            user_io_r <= 1'b0;
            img_valid_r <= 1'b0;
            img_data_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            src_r <= src_nxt;
            cnt_r <= cnt_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            nbit_r <= nbit_nxt;
            shift_r <= shift_nxt;
            byte_r <= byte_nxt;
            push_r <= push_nxt;
            init_cnt_r <= init_cnt_nxt;
            initd_en_r <= initd_en_nxt;
            od_r <= od_nxt;
            user_mode_r <= st_nxt == ST_USER;
            // data pin turns into a user input
            user_io_r <= (st_nxt == ST_USER) && pin_s_r.serial_config_in;
            img_valid_r <= img_valid_nxt;
            img_data_r <= img_data_nxt;
        end
    end

    // outputs straight from flops; the image stream pays one stage
    // of latency for it, and a byte moves on valid with ready
    assign pins_out = od_r;
    assign user_mode = user_mode_r;
    assign user_io_in = user_io_r;
    assign image_valid = img_valid_r;
    assign image_data = img_data_r;

    // ==========================================================
    // checks; they assume clk_en high while they watch
    a_req_restart: assert property (
        @(posedge mclk) disable iff (!resetn)
        ($fell(pin_s_r.config_req_n) && st_r != ST_POR) |=> st_r == ST_HOLD)
        else $error("request low did not restart");
    a_user_lines: assert property (
        @(posedge mclk) disable iff (!resetn)
        user_mode_r |-> (!od_r.status_oe && !od_r.done_oe))
        else $error("line driven in user mode");
    a_por_status: assert property (
        @(posedge mclk) disable iff (!resetn)
        st_r == ST_POR |-> (od_r.status_oe && od_r.done_oe))
        else $error("status released during power-on");
    a_req_lines_low: assert property (
        @(posedge mclk) disable iff (!resetn)
        $fell(pin_s_r.config_req_n) |=> (od_r.status_oe && od_r.done_oe))
        else $error("lines not low after request");
    a_status_hold: assert property (
        @(posedge mclk) disable iff (!resetn)
        (st_r == ST_HOLD && pin_s_r.config_req_n) |=> od_r.status_oe [*8])
        else $error("status released too early");
    a_bit_on_rise: assert property (
        @(posedge mclk) disable iff (!resetn)
        (st_r == ST_LOAD && !cclk_rise && pin_s_r.config_req_n)
        |=> bit_cnt_r == $past(bit_cnt_r))
        else $error("bit taken without a rising edge");
    a_done_low: assert property (
        @(posedge mclk) disable iff (!resetn)
        (st_r == ST_LOAD || st_r == ST_STAT) |-> od_r.done_oe)
        else $error("done released during load");
    a_done_full: assert property (
        @(posedge mclk) disable iff (!resetn)
        $fell(od_r.done_oe) |-> (bit_cnt_r == IMG_END && st_r == ST_WAIT2))
        else $error("done released before full image");
    a_init_count: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(user_mode_r) |-> $past(init_cnt_r) == INIT_LAST)
        else $error("user mode before init count");
    a_initd_low: assert property (
        @(posedge mclk) disable iff (!resetn)
        (st_r == ST_INIT && initd_en_r) |-> od_r.initd_oe)
        else $error("init pin released early");
    a_user_io: assert property (
        @(posedge mclk) disable iff (!resetn)
        (st_r == ST_USER && $past(st_r) == ST_USER)
        |-> user_io_r == $past(pin_s_r.serial_config_in))
        else $error("user input not following pin");
    a_img_hold: assert property (
        @(posedge mclk) disable iff (!resetn)
        (img_valid_r && !image_ready && !fifo_clr)
        |=> (img_valid_r && $stable(img_data_r)))
        else $error("image byte dropped before taken");
endmodule
`default_nettype wire

/* File: verification/cfl_host.sv */
/*
 * host model of the serial configuration port: request pulse, bit shift
 * and the start-up falling edges. assumes the bench resolves the
 * open-drain status and done lines with pull-ups.
 */
`timescale 1ns/1ps
`default_nettype none
module cfl_host (
    input wire logic status_line,
    input wire logic done_line,
    output logic config_req_n,
    output logic config_clock,
    output logic serial_config_in,
    output logic busy
);
    // ==========================================================
    // link timing
    // 8 MHz bit rate, unrelated in phase to mclk
    localparam real HALF_NS = 62.5;

    initial begin
        config_req_n = 1'b1;
        config_clock = 1'b0;
        serial_config_in = 1'b0;
        busy = 1'b0;
    end

    // ==========================================================
    // request
    // pulse longer than 2 us
    task automatic request();
        config_req_n = 1'b0;
        #2100;
        config_req_n = 1'b1;
    endtask

    // ==========================================================
    // image shift
    // single-pin scheme only; four-bit flash lines not driven
    // status watched, lsb first, one bit a rise
    task automatic load(input logic [7:0] img[$], input int pause);
        wait (status_line === 1'b1);
        #2100;
        busy = 1'b1;
        for (int i = 0; i < img.size(); i++) begin
            for (int b = 0; b < 8; b++) begin
                config_clock = 1'b0;
                serial_config_in = img[i][b];
                // slow host: clock held low mid-image
                if (b == 0 && i == pause) #1000;
                #HALF_NS;
                config_clock = 1'b1;
                if (i == img.size() - 1 && b == 7) busy = 1'b0;
                #HALF_NS;
            end
        end
        // released data line must not keep the last bit
        serial_config_in = ~serial_config_in;
    endtask

    // ==========================================================
    // start-up edges
    // two falls after done, clock then held low
    task automatic start_init();
        wait (done_line === 1'b1);
        config_clock = 1'b0;
        #HALF_NS;
        config_clock = 1'b1;
        #HALF_NS;
        config_clock = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
/*
 * self-checking bench of the configuration loader against a host model.
 * assumes open-drain lines with pull-ups, resolved here from the enables.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cfl_pkg::*;
    localparam int NBYTES = 20;
    localparam int SLOW = 50;
    logic mclk, resetn, uclk, req_n, cclk, host_din, own_pin, use_own;
    logic busy, status_line, done_line, init_done_en, user_mode;
    logic user_io_in, image_valid, image_ready, stall, clk_en;
    logic [1:0] init_clk_sel;
    logic [7:0] image_data;
    cfl_pins_in_t pi;
    cfl_pins_out_t po;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;

    // ==========================================================
    // wiring
    assign status_line = po.status_oe ? 1'b0 : 1'b1;
    assign done_line = po.done_oe ? 1'b0 : 1'b1;
    assign pi = '{req_n, cclk, use_own ? own_pin : host_din, uclk,
        status_line};

    cfl_loader #(.POR_CYC(20), .STATUS_LOW_CYC(SLOW),
        .IMAGE_BITS(NBYTES * 8)) DUT (
        .mclk(mclk), .resetn(resetn), .clk_en(clk_en),
        .pins_in(pi), .pins_out(po), .init_clk_sel(init_clk_sel),
        .init_done_en(init_done_en), .user_mode(user_mode),
        .user_io_in(user_io_in), .image_data(image_data),
        .image_valid(image_valid), .image_ready(image_ready));

    cfl_host host (.status_line(status_line), .done_line(done_line),
        .config_req_n(req_n), .config_clock(cclk),
        .serial_config_in(host_din), .busy(busy));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        uclk = 1'b0;
        forever #30 uclk = ~uclk;
    end

    // ==========================================================
    // compare and closing
    task automatic chk1(input logic got, input logic exp, input string s);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, s);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: byte %h not %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d, failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic line(input int w);
        case (w)
            0: return status_line;
            1: return done_line;
            default: return user_mode;
        endcase
    endfunction
    // bounded wait, n is the count of edges spent
    task automatic wait_lvl(input int w, input logic lvl, input int lim,
            output int n);
        n = 0;
        while (line(w) !== lvl && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    // ==========================================================
    // byte model and stalling consumer
    // random ready, back to back too: a byte moves on valid with ready
    always @(posedge mclk) begin
        cyc++;
        if (busy === 1'b1) chk1(done_line, 1'b0, "done early");
        if (image_valid === 1'b1 && image_ready === 1'b1) begin
            chk1(exp_q.size() > 0, 1'b1, "extra byte");
            if (exp_q.size() > 0) chk8(image_data, exp_q.pop_front());
        end
        #1;
        image_ready = !stall && ($urandom_range(1) == 1);
    end

    // ==========================================================
    // one reconfiguration through to user mode
    task automatic config_run(input logic [1:0] sel, input logic den,
            input int pause, input int lo, input int hi);
        int n;
        int k;
        int t0;
        logic [7:0] img[$];
        exp_q.delete();
        init_clk_sel = sel;
        init_done_en = den;
        fork
            host.request();
            begin
                wait_lvl(0, 1'b0, 100, n);
                wait_lvl(1, 1'b0, 100, k);
            end
        join
        // buffer cleared by the restart, stale bytes gone
        stall = 1'b0;
        chk1(n + k <= 60, 1'b1, "request to lines low");
        chk1(user_mode, 1'b0, "user mode kept");
        wait_lvl(0, 1'b1, 1000, n);
        chk1(n >= SLOW && n <= SLOW + 10, 1'b1, "status low time");
        for (int i = 0; i < NBYTES; i++) begin
            img.push_back(8'($urandom));
            exp_q.push_back(img[i]);
        end
        host.load(img, pause);
        wait_lvl(1, 1'b1, 100, n);
        chk1(done_line, 1'b1, "done after image");
        t0 = cyc;
        host.start_init();
        repeat (10) @(posedge mclk);
        #1;
        chk1(po.initd_oe, den, "init pin during init");
        chk1(user_mode, 1'b0, "user mode early");
        wait_lvl(2, 1'b1, 60000, n);
        k = cyc - t0;
        chk1(k >= lo && k <= hi, 1'b1, "done to user mode");
        chk1(po.initd_oe, 1'b0, "init pin released");
        chk1(status_line & done_line & req_n, 1'b1, "lines");
        chk1(exp_q.size() == 0, 1'b1, "bytes missing");
        use_own = 1'b1;
        for (int i = 0; i < 8; i++) begin
            own_pin = 1'($urandom);
            repeat (6) @(posedge mclk);
            #1;
            chk1(user_io_in, own_pin, "user pin");
        end
        // clock enable low freezes the pin path
        clk_en = 1'b0;
        own_pin = !own_pin;
        repeat (6) @(posedge mclk);
        #1;
        chk1(user_io_in, !own_pin, "frozen by clock enable");
        clk_en = 1'b1;
        use_own = 1'b0;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] img[$];
        resetn = 1'b0;
        own_pin = 1'b0;
        use_own = 1'b0;
        stall = 1'b1;
        clk_en = 1'b1;
        image_ready = 1'b0;
        init_clk_sel = 2'h0;
        init_done_en = 1'b0;
        void'($urandom(32'h708b_3c0d));
        repeat (20) @(posedge mclk);
        #1;
        resetn = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk1(status_line, 1'b0, "status after power-up");
        chk1(done_line, 1'b0, "done after power-up");
        // consumer stalled: the buffer fills and refuses the image
        for (int i = 0; i < NBYTES; i++) img.push_back(8'($urandom));
        host.load(img, -1);
        repeat (40) @(posedge mclk);
        #1;
        chk1(done_line, 1'b0, "done after overflow");
        chk1(status_line, 1'b0, "status after overflow");
        config_run(2'h0, 1'b1, 9, 17500, 43700);
        config_run(2'h1, 1'b0, -1, 51450, 51556);
        test_done();
    end

    initial begin
        #1_100_000;
        n_fail++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        test_done();
    end
endmodule
`default_nettype wire
